// file: include/capture_edge_pkg.sv
// Constants, types and decode helpers for the capture edge and mask block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and 8-bit registers.
`default_nettype none

package capture_edge_pkg;

  localparam int unsigned CHANNELS = 8;
  localparam int unsigned ADDR_W = 5;

  // Register byte offsets, one aligned word each
  localparam logic [4:0] OFS_EDGE_HIGH = 5'h00;
  localparam logic [4:0] OFS_EDGE_LOW = 5'h04;
  localparam logic [4:0] OFS_CHAN_MASK = 5'h08;
  localparam logic [4:0] OFS_MASK_TWO = 5'h0C;
  localparam logic [4:0] OFS_CHAN_FLAGS = 5'h10;
  localparam logic [4:0] OFS_CAP_SELECT = 5'h14;
  localparam logic [4:0] OFS_OVF_FLAG = 5'h18;

  // Reset values
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_CHAN_MASK = 8'h00;
  localparam logic [7:0] RST_MASK_TWO = 8'h00;
  localparam logic [7:0] RST_CAP_SELECT = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // Second mask register field positions
  localparam int unsigned POS_OVF_EN = 7;
  localparam int unsigned POS_ZERO = 6;
  localparam int unsigned POS_PULLUP = 5;
  localparam int unsigned POS_REDUCED = 4;
  localparam int unsigned POS_CNT_RST = 3;
  localparam int unsigned POS_PRESCALE = 0;
  localparam int unsigned PRESCALE_W = 3;
  localparam logic [7:0] MASK_TWO_WR = 8'hBF;

  // Position of the overflow flag in its status word
  localparam int unsigned POS_OVF_FLAG = 7;

  // Edge selector codes, upper bit first
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_e;

  // Fields of the second mask register, driven out of the block
  typedef struct packed {
    logic overflow_irq_enable;
    logic timer_pin_pullup_enable;
    logic timer_pin_reduced_drive;
    logic counter_reset_on_match;
    logic [2:0] prescale_sel;
  } timer_ctrl_s;

  // Avalon request group
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_s;

  // Does this pin transition match the selector
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_ANY: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // Selector pair of a channel from the two control bytes
  function automatic logic [1:0] edge_pair(input logic [15:0] ctrl, input int unsigned ch);
    edge_pair = ctrl[2*ch +: 2];
  endfunction : edge_pair

endpackage : capture_edge_pkg

`default_nettype wire

// file: logic/capture_edge_detect.sv
// Bank of per-channel edge detectors on the timer capture pins.
// Assumes pins are already synchronous to clk; emits one-cycle capture pulses.
`timescale 1ns/1ps
`default_nettype none

module capture_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and configuration
  input wire logic [7:0] pin_in,
  input wire logic [15:0] edge_ctrl,
  input wire logic [7:0] capture_or_compare_select,
  // Capture pulses
  output logic [7:0] capture_strobe
);

  logic [7:0] prev_r;
  logic prev_valid_r;
  logic [7:0] strobe_nxt;

  // Last pin sample; the first sample after reset is never an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 8'h00;
      prev_valid_r <= 1'b0;
    end else begin
      prev_r <= pin_in;
      prev_valid_r <= 1'b1;
    end
  end

  // Per-channel decode, only on channels set up for input capture
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_chan
      assign strobe_nxt[ch] = prev_valid_r & ~capture_or_compare_select[ch] &
        capture_edge_pkg::edge_hit(capture_edge_pkg::edge_pair(edge_ctrl, ch),
                                   prev_r[ch], pin_in[ch]);
    end
  endgenerate

  // Registered pulse output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_strobe <= 8'h00;
    end else begin
      capture_strobe <= strobe_nxt;
    end
  end

endmodule : capture_edge_detect

`default_nettype wire

// file: logic/capture_edge_and_irq_mask.sv
// Capture edge selection, channel flags and interrupt masks of a 16-bit timer.
// Assumes an Avalon-MM master on clk, capture pins synchronous to clk, and
// one-cycle compare and overflow pulses from the counter logic outside.
//
// How it works
// - Selector 00 disables capture; 01 captures rising edges only.
// - Selector 10 captures falling edges only.
// - Selector 11 captures on every transition.
// - Eight selector pairs: high byte holds channels 7-4, low byte 3-0.
// - Edge bytes and channel mask reset to zero, read/write anytime.
// - Channel mask bit n enables channel flag bit n.
// - Masked-off flag still sets but raises no interrupt.
// - Unmasked set flag raises the interrupt.
// - Edge selection acts only on channels configured as input capture.
`timescale 1ns/1ps
`default_nettype none

module capture_edge_and_irq_mask (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timer pins and counter events
  input wire logic [7:0] capture_pin_in,
  input wire logic [7:0] compare_event,
  input wire logic overflow_event,
  // Capture pulses to the holding latches
  output logic [7:0] capture_strobe,
  // Configuration out to the rest of the timer
  output logic [7:0] capture_or_compare_select,
  output capture_edge_pkg::timer_ctrl_s timer_ctrl,
  // Interrupts
  output logic channel_irq,
  output logic overflow_irq
);

  capture_edge_pkg::avmm_req_s req;
  capture_edge_pkg::bus_state_e bus_state_r;
  capture_edge_pkg::bus_state_e bus_state_nxt;

  logic [7:0] capture_edge_ctrl_high_r;
  logic [7:0] capture_edge_ctrl_low_r;
  logic [7:0] channel_irq_mask_r;
  logic [7:0] timer_irq_mask_two_r;
  logic [7:0] cap_select_r;
  logic [7:0] channel_flag_status_r;
  logic overflow_flag_r;
  logic [7:0] capture_hit;
  logic [7:0] rd_value;
  logic wr_fire;
  logic rd_fire;
  logic lane0;

  assign req = '{address: address, read: read, write: write,
                 writedata: writedata, byteenable: byteenable};

  // Transfer completes at the edge where waitrequest is seen low
  assign wr_fire = (bus_state_r == capture_edge_pkg::BUS_ACK) & req.write;
  assign rd_fire = (bus_state_r == capture_edge_pkg::BUS_ACK) & req.read;
  assign lane0 = req.byteenable[0];

  // One wait state: request seen in idle, answered in the next cycle
  always_comb begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      capture_edge_pkg::BUS_IDLE: begin
        if (req.read | req.write) begin
          bus_state_nxt = capture_edge_pkg::BUS_ACK;
        end
      end
      capture_edge_pkg::BUS_ACK: begin
        bus_state_nxt = capture_edge_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_nxt = capture_edge_pkg::BUS_IDLE;
      end
    endcase
  end

  // Handshake state and waitrequest flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_r <= capture_edge_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      bus_state_r <= bus_state_nxt;
      waitrequest <= (bus_state_nxt != capture_edge_pkg::BUS_ACK);
    end
  end

  // Read mux; unmapped offsets and upper bits read zero
  always_comb begin
    unique case (req.address)
      capture_edge_pkg::OFS_EDGE_HIGH: rd_value = capture_edge_ctrl_high_r;
      capture_edge_pkg::OFS_EDGE_LOW: rd_value = capture_edge_ctrl_low_r;
      capture_edge_pkg::OFS_CHAN_MASK: rd_value = channel_irq_mask_r;
      capture_edge_pkg::OFS_MASK_TWO: rd_value = timer_irq_mask_two_r;
      capture_edge_pkg::OFS_CHAN_FLAGS: rd_value = channel_flag_status_r;
      capture_edge_pkg::OFS_CAP_SELECT: rd_value = cap_select_r;
      capture_edge_pkg::OFS_OVF_FLAG: rd_value = {overflow_flag_r, 7'h00};
      default: rd_value = 8'h00;
    endcase
  end

  // Read data captured as the request is first seen, stable while acked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if ((bus_state_r == capture_edge_pkg::BUS_IDLE) & req.read) begin
      readdata <= {24'h00_0000, rd_value};
    end
  end

  // Edge control bytes, no mode restriction on access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_edge_ctrl_high_r <= capture_edge_pkg::RST_EDGE;
      capture_edge_ctrl_low_r <= capture_edge_pkg::RST_EDGE;
    end else if (wr_fire & lane0) begin
      if (req.address == capture_edge_pkg::OFS_EDGE_HIGH) begin
        capture_edge_ctrl_high_r <= req.writedata[7:0];
      end
      if (req.address == capture_edge_pkg::OFS_EDGE_LOW) begin
        capture_edge_ctrl_low_r <= req.writedata[7:0];
      end
    end
  end

  // Channel interrupt mask, one enable per channel flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_irq_mask_r <= capture_edge_pkg::RST_CHAN_MASK;
    end else if (wr_fire & lane0 & (req.address == capture_edge_pkg::OFS_CHAN_MASK)) begin
      channel_irq_mask_r <= req.writedata[7:0];
    end
  end

  // Second mask register; bit 6 is never stored so it reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq_mask_two_r <= capture_edge_pkg::RST_MASK_TWO;
    end else if (wr_fire & lane0 & (req.address == capture_edge_pkg::OFS_MASK_TWO)) begin
      timer_irq_mask_two_r <= req.writedata[7:0] & capture_edge_pkg::MASK_TWO_WR;
    end
  end

  // Capture or compare choice per channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_select_r <= capture_edge_pkg::RST_CAP_SELECT;
    end else if (wr_fire & lane0 & (req.address == capture_edge_pkg::OFS_CAP_SELECT)) begin
      cap_select_r <= req.writedata[7:0];
    end
  end

  // Edge detector bank; channel 7-4 pairs from the high byte
  capture_edge_detect u_detect (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(capture_pin_in),
    .edge_ctrl({capture_edge_ctrl_high_r, capture_edge_ctrl_low_r}),
    .capture_or_compare_select(cap_select_r),
    .capture_strobe(capture_hit)
  );

  assign capture_strobe = capture_hit;

  // Sticky channel flags; a read clears only the bits it returned, so a flag
  // set after the read data was latched survives, and a same-cycle event wins.
  // Flags set even when masked so software can still poll them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_flag_status_r <= capture_edge_pkg::RST_FLAGS;
    end else begin
      channel_flag_status_r <=
        ((rd_fire & (req.address == capture_edge_pkg::OFS_CHAN_FLAGS)) ?
         (channel_flag_status_r & ~readdata[7:0]) : channel_flag_status_r) |
        capture_hit | (compare_event & cap_select_r);
    end
  end

  // Sticky overflow flag with the same clear rule
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_r <= 1'b0;
    end else begin
      overflow_flag_r <= ((rd_fire & (req.address == capture_edge_pkg::OFS_OVF_FLAG)) ?
                          (overflow_flag_r & ~readdata[capture_edge_pkg::POS_OVF_FLAG]) :
                          overflow_flag_r) | overflow_event;
    end
  end

  // Interrupt levels, one cycle behind the flags so outputs stay registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      channel_irq <= |(channel_flag_status_r & channel_irq_mask_r);
      overflow_irq <= overflow_flag_r &
                      timer_irq_mask_two_r[capture_edge_pkg::POS_OVF_EN];
    end
  end

  // Configuration fields driven out from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_or_compare_select <= capture_edge_pkg::RST_CAP_SELECT;
      timer_ctrl <= '0;
    end else begin
      capture_or_compare_select <= cap_select_r;
      timer_ctrl.overflow_irq_enable <=
        timer_irq_mask_two_r[capture_edge_pkg::POS_OVF_EN];
      timer_ctrl.timer_pin_pullup_enable <=
        timer_irq_mask_two_r[capture_edge_pkg::POS_PULLUP];
      timer_ctrl.timer_pin_reduced_drive <=
        timer_irq_mask_two_r[capture_edge_pkg::POS_REDUCED];
      timer_ctrl.counter_reset_on_match <=
        timer_irq_mask_two_r[capture_edge_pkg::POS_CNT_RST];
      timer_ctrl.prescale_sel <=
        timer_irq_mask_two_r[capture_edge_pkg::POS_PRESCALE +: capture_edge_pkg::PRESCALE_W];
    end
  end

endmodule : capture_edge_and_irq_mask

`default_nettype wire

// file: test/capture_edge_properties.sv
// Port checker for the capture edge and mask block.
// Assumes one clk domain; bound to the block below.
`timescale 1ns/1ps
`default_nettype none
module capture_edge_properties (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Timer side
  input wire logic [7:0] capture_pin_in,
  input wire logic [7:0] compare_event,
  input wire logic overflow_event,
  input wire logic [7:0] capture_strobe,
  input wire logic [7:0] capture_or_compare_select,
  input wire logic channel_irq,
  input wire logic overflow_irq
);
  // One domain, so shared clocking and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Accepted transfer; the only cause of a mask change or read clear
  logic acc;
  assign acc = (read | write) & ~waitrequest;
  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than a cycle");
  idle_wait_a: assert property (!read && !write |=> waitrequest)
    else $error("answer without request");
  upper_zero_a: assert property (readdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  strobe_cause_a: assert property ((capture_strobe & ~($past(capture_pin_in) ^
    $past(capture_pin_in, 2))) == 8'h00) else $error("strobe without pin change");
  sel_blocks_a: assert property ((capture_strobe & capture_or_compare_select &
    $past(capture_or_compare_select)) == 8'h00) else $error("strobe on compare channel");
  irq_rise_a: assert property ($rose(channel_irq) |-> $past(|capture_strobe ||
    |compare_event || acc, 2) || $past(acc)) else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(channel_irq) |-> $past(acc) || $past(acc, 2))
    else $error("irq fell without access");
  ovf_rise_a: assert property ($rose(overflow_irq) |-> $past(overflow_event || acc) ||
    $past(overflow_event || acc, 2)) else $error("overflow irq without cause");
endmodule : capture_edge_properties
bind capture_edge_and_irq_mask capture_edge_properties chk (.clk, .rst_n, .read, .write,
  .readdata, .waitrequest, .capture_pin_in, .compare_event, .overflow_event,
  .capture_strobe, .capture_or_compare_select, .channel_irq, .overflow_irq);
`default_nettype wire

// file: test/capture_pin_model.sv
// Model of the sources wired to the capture pins.
// Assumes the bench sets wanted levels; pins follow one clk edge later.
`timescale 1ns/1ps
`default_nettype none
module capture_pin_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wanted levels in, pins out
  input wire logic [7:0] level,
  output logic [7:0] pins
);
  // Registered, since the block takes its pins as synchronous to clk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= 8'h00;
    end else begin
      pins <= level;
    end
  end
endmodule : capture_pin_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the capture edge and mask block.
// Assumes the checker binds itself; pins come from capture_pin_model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk = 0, rst_n = 0, read = 0, write = 0, overflow_event = 0, clr = 0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [7:0] level = 8'h00, compare_event = 8'h00, pins, capture_strobe, seen, sel;
  logic waitrequest, channel_irq, overflow_irq;
  capture_edge_pkg::timer_ctrl_s timer_ctrl;
  int fails = 0, checked = 0;
  logic [15:0] cfg [5] = '{16'h0000, 16'h5555, 16'hAAAA, 16'hFFFF, 16'h55AA};
  logic [4:0] ofs [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h14, 5'h1C};
  // 10 MHz clock
  always #50 clk = ~clk;
  // Strobes last one cycle, so gather them between clears
  always @(posedge clk) seen <= clr ? 8'h00 : seen | capture_strobe;
  capture_edge_and_irq_mask dut (.clk, .rst_n, .address, .read, .write, .writedata,
    .byteenable(4'h1), .readdata, .waitrequest, .capture_pin_in(pins), .compare_event,
    .overflow_event, .capture_strobe, .capture_or_compare_select(sel), .timer_ctrl,
    .channel_irq, .overflow_irq);
  capture_pin_model pm (.clk, .rst_n, .level, .pins);
  task automatic stop_test;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // One transfer; request held until waitrequest is sampled low
  task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d);
    int n;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin fails++; stop_test(); end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wt(input logic [4:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wt
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    `CHK("readdata", {24'h0, e}, q)
  endtask : rd
  task automatic pins_to(input logic [7:0] v, input logic [7:0] e);
    clr <= 1'b1;
    level <= v;
    @(posedge clk);
    clr <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("strobes", e, seen)
  endtask : pins_to
  // Interrupt level is read after the wait, not when the task is called
  task automatic wait_chk(input logic e, input bit ovf);
    repeat (3) @(posedge clk);
    if (ovf) `CHK("overflow_irq", e, overflow_irq)
    else `CHK("channel_irq", e, channel_irq)
  endtask : wait_chk
  // Channels expected to fire for a rising (0) or falling (1) transition
  function automatic logic [7:0] hits(input logic [15:0] c, input bit fall);
    for (int i = 0; i < 8; i++) hits[i] = c[2*i + fall];
  endfunction : hits
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    for (int k = 0; k < 5; k++) begin
      wt(5'h00, cfg[k][15:8]);
      wt(5'h04, cfg[k][7:0]);
      rd(5'h00, cfg[k][15:8]);
      rd(5'h04, cfg[k][7:0]);
      pins_to(8'hFF, hits(cfg[k], 1'b0));
      pins_to(8'h00, hits(cfg[k], 1'b1));
    end
    // Compare-mode channels must ignore their pins
    wt(5'h00, 8'hFF);
    wt(5'h04, 8'hFF);
    wt(5'h14, 8'h0F);
    rd(5'h14, 8'h0F);
    `CHK("select", 8'h0F, sel)
    pins_to(8'hFF, 8'hF0);
    rd(5'h10, 8'hFF);
    rd(5'h10, 8'h00);
    // Bit 4 is a capture channel, so its compare pulse must not set a flag
    compare_event <= 8'h12;
    @(posedge clk);
    compare_event <= 8'h00;
    wait_chk(1'b0, 1'b0);
    wt(5'h08, 8'hFD);
    wait_chk(1'b0, 1'b0);
    wt(5'h08, 8'h02);
    wait_chk(1'b1, 1'b0);
    rd(5'h10, 8'h02);
    wait_chk(1'b0, 1'b0);
    wt(5'h0C, 8'hFF);
    rd(5'h0C, 8'hBF);
    `CHK("ctrl", 7'h7F, timer_ctrl)
    overflow_event <= 1'b1;
    @(posedge clk);
    overflow_event <= 1'b0;
    wait_chk(1'b1, 1'b1);
    rd(5'h18, 8'h80);
    wait_chk(1'b0, 1'b1);
    // Mid-run reset must bring the registers read here, timer_ctrl and select back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(5'h10, 8'h00);
    `CHK("ctrl", 7'h00, timer_ctrl)
    `CHK("select", 8'h00, sel)
    stop_test();
  end
endmodule : testbench
`default_nettype wire
